/* verilog/pct_pkg.sv */
// constants, field layout and types of the configuration cycle translator
package pct_pkg;
	// ----------------------------------------
	// processor-side offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_LOW_WORD  = 12'hcf8;
	localparam logic [11:0] OFS_HIGH_WORD = 12'hcfc;

	// ----------------------------------------
	// address register fields (pci byte order)
	// ----------------------------------------
	localparam int          EN_POS      = 31;
	localparam int          BUS_LSB     = 16;
	localparam int          DEV_LSB     = 11;
	localparam int          FUN_LSB     = 8;
	localparam int          REG_LSB     = 2;
	localparam logic [31:0] ADDR_WR_MASK = 32'h80fffffc;
	localparam logic [31:0] ADDR_RESET   = 32'h00000000;

	// ----------------------------------------
	// special-cycle field pattern
	// ----------------------------------------
	localparam logic [4:0] DEV_ALL_ONES = 5'h1f;
	localparam logic [2:0] FUN_ALL_ONES = 3'h7;
	localparam logic [5:0] REG_ZERO     = 6'h00;

	// ----------------------------------------
	// pci commands and type bits
	// ----------------------------------------
	localparam logic [3:0] CMD_SPECIAL  = 4'h1;
	localparam logic [3:0] CMD_IO_RD    = 4'h2;
	localparam logic [3:0] CMD_IO_WR    = 4'h3;
	localparam logic [3:0] CMD_CFG_RD   = 4'ha;
	localparam logic [3:0] CMD_CFG_WR   = 4'hb;
	localparam logic [1:0] TYPE0_BITS   = 2'h0;
	localparam logic [1:0] TYPE1_BITS   = 2'h1;
	localparam int         IDSEL_LSB    = 11;
	localparam int         IDSEL_COUNT  = 21;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BUSY = 2'h1,
		ST_DONE = 2'h3
	} pct_state_t;
endpackage : pct_pkg

/* verilog/pct_cycle_if.sv */
// carrier between the translator control and its cycle encoder
interface pct_cycle_if;
	logic        enable;
	logic [7:0]  busNum;
	logic [4:0]  device_number_field;
	logic [2:0]  function_number_field;
	logic [5:0]  regNum;
	logic        isWrite;
	logic [11:0] ioAddr;
	logic [3:0]  pciCmd;
	logic [31:0] pciAddr;
	logic        isSpecial;

	modport ctl (output enable, busNum, device_number_field, function_number_field, regNum, isWrite, ioAddr,
		input pciCmd, pciAddr, isSpecial);
	modport enc (input enable, busNum, device_number_field, function_number_field, regNum, isWrite, ioAddr,
		output pciCmd, pciAddr, isSpecial);
endinterface : pct_cycle_if

/* verilog/pct_cycle_encoder.sv */
// turns the address register fields into a pci command and address phase value
module pct_cycle_encoder (
	// fields in, cycle out
	pct_cycle_if.enc cyc
);
	// ----------------------------------------
	// classification
	// ----------------------------------------
	wire        busZero  = (cyc.busNum == 8'h00);
	wire        specPat  = (cyc.device_number_field == pct_pkg::DEV_ALL_ONES)
		&& (cyc.function_number_field == pct_pkg::FUN_ALL_ONES) && (cyc.regNum == pct_pkg::REG_ZERO);
	// device-number encoding is a plain one-hot idsel; devices past the idsel range select nothing
	wire [20:0] idselHot = (cyc.device_number_field < 5'(pct_pkg::IDSEL_COUNT))
		? (21'h000001 << cyc.device_number_field) : 21'h000000;
	wire [31:0] type0Addr = {idselHot, cyc.function_number_field, cyc.regNum, pct_pkg::TYPE0_BITS};
	wire [31:0] type1Addr = {8'h00, cyc.busNum, cyc.device_number_field, cyc.function_number_field,
		cyc.regNum, pct_pkg::TYPE1_BITS};
	wire [3:0]  cfgCmd   = cyc.isWrite ? pct_pkg::CMD_CFG_WR : pct_pkg::CMD_CFG_RD;
	wire [3:0]  ioCmd    = cyc.isWrite ? pct_pkg::CMD_IO_WR : pct_pkg::CMD_IO_RD;

	// ----------------------------------------
	// selection
	// ----------------------------------------
	assign cyc.isSpecial = cyc.enable && specPat && busZero;
	assign cyc.pciCmd  = !cyc.enable ? ioCmd
		: cyc.isSpecial ? pct_pkg::CMD_SPECIAL : cfgCmd;
	assign cyc.pciAddr = !cyc.enable ? {20'h00000, cyc.ioAddr}
		: cyc.isSpecial ? 32'h00000000
		: busZero ? type0Addr : type1Addr;
endmodule : pct_cycle_encoder

/* verilog/pct_translator.sv */
// configuration address register and data port translating into pci cycles
module pct_translator (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// processor bus request
	input  wire logic        cpuReq,
	input  wire logic        cpuWrite,
	input  wire logic [11:0] cpuAddr,
	input  wire logic [3:0]  cpuByteEn,
	input  wire logic [31:0] cpuWdata,
	input  wire logic        bigEndianMode,
	// processor bus answer
	output logic             cpuAck,
	output logic [31:0]      cpuRdata,
	// pci cycle request
	output logic             pciReq,
	output logic [3:0]       pciCmd,
	output logic [31:0]      pciAddr,
	output logic [3:0]       pciByteEn,
	output logic [31:0]      pciWdata,
	// pci cycle completion
	input  wire logic        pciDone,
	input  wire logic [31:0] pciRdata
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	pct_pkg::pct_state_t state_r;
	pct_pkg::pct_state_t state_nxt;
	logic [31:0]         addrReg_r;
	logic [31:0]         addrReg_nxt;
	logic                cpuAck_r;
	logic [31:0]         cpuRdata_r;
	logic                pciReq_r;
	logic [3:0]          pciCmd_r;
	logic [31:0]         pciAddr_r;
	logic [3:0]          pciByteEn_r;
	logic [31:0]         pciWdata_r;

	pct_cycle_if cyc ();

	// ----------------------------------------
	// lane steering and decode
	// ----------------------------------------
	// lane k of the processor word is the byte at offset word+k; little-endian reverses lanes
	wire [31:0] inLanes   = bigEndianMode ? cpuWdata
		: {cpuWdata[7:0], cpuWdata[15:8], cpuWdata[23:16], cpuWdata[31:24]};
	wire [3:0]  inBe      = bigEndianMode ? cpuByteEn
		: {cpuByteEn[0], cpuByteEn[1], cpuByteEn[2], cpuByteEn[3]};
	wire [31:0] outAddrReg = bigEndianMode ? addrReg_r
		: {addrReg_r[7:0], addrReg_r[15:8], addrReg_r[23:16], addrReg_r[31:24]};
	wire [31:0] outPciData = bigEndianMode ? pciRdata
		: {pciRdata[7:0], pciRdata[15:8], pciRdata[23:16], pciRdata[31:24]};
	wire [11:0] addrOfs   = bigEndianMode ? pct_pkg::OFS_LOW_WORD : pct_pkg::OFS_HIGH_WORD;
	wire [11:0] dataOfs   = bigEndianMode ? pct_pkg::OFS_HIGH_WORD : pct_pkg::OFS_LOW_WORD;
	wire        idle      = (state_r == pct_pkg::ST_IDLE);
	wire        hitAddr   = idle && cpuReq && (cpuAddr[11:2] == addrOfs[11:2]);
	wire        hitData   = idle && cpuReq && (cpuAddr[11:2] == dataOfs[11:2]);
	wire        hitOther  = idle && cpuReq && !hitAddr && !hitData;
	wire [31:0] laneMask  = {{8{inBe[3]}}, {8{inBe[2]}}, {8{inBe[1]}}, {8{inBe[0]}}};
	wire [31:0] wrMask    = laneMask & pct_pkg::ADDR_WR_MASK;

	// ----------------------------------------
	// encoder hookup
	// ----------------------------------------
	assign cyc.enable                = addrReg_r[pct_pkg::EN_POS];
	assign cyc.busNum                = addrReg_r[pct_pkg::BUS_LSB +: 8];
	assign cyc.device_number_field   = addrReg_r[pct_pkg::DEV_LSB +: 5];
	assign cyc.function_number_field = addrReg_r[pct_pkg::FUN_LSB +: 3];
	assign cyc.regNum                = addrReg_r[pct_pkg::REG_LSB +: 6];
	assign cyc.isWrite               = cpuWrite;
	assign cyc.ioAddr                = dataOfs;

	pct_cycle_encoder i_pct_cycle_encoder (
		.cyc (cyc.enc)
	);

	// only the processor request port writes the register; pci inputs feed read data and sequencing alone
	assign addrReg_nxt = (hitAddr && cpuWrite)
		? ((addrReg_r & ~wrMask) | (inLanes & wrMask)) : addrReg_r;

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			pct_pkg::ST_IDLE: if (hitData) state_nxt = pct_pkg::ST_BUSY;
			pct_pkg::ST_BUSY: if (pciDone && !pciReq_r) state_nxt = pct_pkg::ST_DONE;
			pct_pkg::ST_DONE: state_nxt = pct_pkg::ST_IDLE;
			default:          state_nxt = pct_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_r   <= pct_pkg::ST_IDLE;
			addrReg_r <= pct_pkg::ADDR_RESET;
		end
		else
		begin
			state_r   <= state_nxt;
			addrReg_r <= addrReg_nxt;
		end
	end

	// pci request is a one-cycle pulse; fields hold until the next launch
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pciReq_r    <= 1'b0;
			pciCmd_r    <= 4'h0;
			pciAddr_r   <= 32'h00000000;
			pciByteEn_r <= 4'h0;
			pciWdata_r  <= 32'h00000000;
		end
		else
		begin
			pciReq_r <= hitData;
			if (hitData)
			begin
				pciCmd_r    <= cyc.pciCmd;
				pciAddr_r   <= cyc.pciAddr;
				pciByteEn_r <= inBe;
				pciWdata_r  <= inLanes;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cpuAck_r   <= 1'b0;
			cpuRdata_r <= 32'h00000000;
		end
		else
		begin
			cpuAck_r <= hitAddr || hitOther || (state_nxt == pct_pkg::ST_DONE);
			if (hitAddr)
				cpuRdata_r <= cpuWrite ? 32'h00000000 : outAddrReg;
			else if (hitOther)
				cpuRdata_r <= 32'h00000000;
			else if (state_nxt == pct_pkg::ST_DONE)
				cpuRdata_r <= cpuWrite ? 32'h00000000 : outPciData;
		end
	end

	assign cpuAck    = cpuAck_r;
	assign cpuRdata  = cpuRdata_r;
	assign pciReq    = pciReq_r;
	assign pciCmd    = pciCmd_r;
	assign pciAddr   = pciAddr_r;
	assign pciByteEn = pciByteEn_r;
	assign pciWdata  = pciWdata_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	wire cfgCycle = pciReq_r && ((pciCmd_r == pct_pkg::CMD_CFG_RD) || (pciCmd_r == pct_pkg::CMD_CFG_WR));
	wire busNz    = (addrReg_r[pct_pkg::BUS_LSB +: 8] != 8'h00);
	wire enBit    = addrReg_r[pct_pkg::EN_POS];
	wire specFld  = (addrReg_r[15:2] == {pct_pkg::DEV_ALL_ONES, pct_pkg::FUN_ALL_ONES, pct_pkg::REG_ZERO});

	AST_REG_FIELD: assert property (cfgCycle |-> pciAddr_r[7:2] == addrReg_r[7:2])
		else $error("register number not on address phase");
	AST_FUN_FIELD: assert property (cfgCycle |-> pciAddr_r[10:8] == addrReg_r[10:8])
		else $error("function number not on address phase");
	AST_DEV_TYPE1: assert property (cfgCycle && busNz |-> pciAddr_r[15:11] == addrReg_r[15:11])
		else $error("device number missing in type 1 address");
	AST_TYPE0: assert property (pciReq_r && enBit && !busNz && !specFld
		|-> cfgCycle && pciAddr_r[1:0] == pct_pkg::TYPE0_BITS)
		else $error("bus zero did not give type 0 cycle");
	AST_TYPE1: assert property (pciReq_r && enBit && busNz
		|-> cfgCycle && pciAddr_r[1:0] == pct_pkg::TYPE1_BITS)
		else $error("nonzero bus did not give type 1 cycle");
	AST_SPECIAL: assert property (pciReq_r && enBit && !busNz && specFld
		|-> pciCmd_r == pct_pkg::CMD_SPECIAL)
		else $error("special pattern did not give special cycle");
	AST_SPECIAL_T1: assert property (pciReq_r && enBit && busNz && specFld
		|-> cfgCycle && pciAddr_r[15:8] == 8'hff)
		else $error("special with bus not converted to type 1");
	AST_IO_PASS: assert property (pciReq_r && !enBit
		|-> pciCmd_r == pct_pkg::CMD_IO_RD || pciCmd_r == pct_pkg::CMD_IO_WR)
		else $error("disabled access not passed as i/o");
	AST_ENABLED: assert property (pciReq_r && enBit
		|-> pciCmd_r != pct_pkg::CMD_IO_RD && pciCmd_r != pct_pkg::CMD_IO_WR)
		else $error("enabled access left as i/o");
	AST_RO_ZERO: assert property ((addrReg_r & ~pct_pkg::ADDR_WR_MASK) == 32'h00000000)
		else $error("read-only address bits not zero");
	AST_ADDR_HOLD: assert property (!(hitAddr && cpuWrite) |=> $stable(addrReg_r))
		else $error("address register changed without a processor write");
	AST_LE_LANES: assert property (pciReq_r && !$past(bigEndianMode)
		|-> pciWdata_r[7:0] == $past(cpuWdata[31:24]))
		else $error("little-endian lanes not reversed");
	AST_BE_READ: assert property (hitAddr && !cpuWrite && bigEndianMode
		|=> cpuAck_r && cpuRdata_r == addrReg_r)
		else $error("big-endian address register read wrong");
	AST_PCI_ACK: assert property (state_r == pct_pkg::ST_BUSY && pciDone && !pciReq_r |=> cpuAck_r)
		else $error("data port not acknowledged after pci completion");

	COV_TYPE0:   cover property (cfgCycle && pciAddr_r[1:0] == pct_pkg::TYPE0_BITS);
	COV_TYPE1:   cover property (cfgCycle && pciAddr_r[1:0] == pct_pkg::TYPE1_BITS);
	COV_SPECIAL: cover property (pciReq_r && pciCmd_r == pct_pkg::CMD_SPECIAL);
	COV_IO:      cover property (pciReq_r && pciCmd_r == pct_pkg::CMD_IO_WR);
endmodule : pct_translator

/* sim/pct_pci_target.sv */
// pci-side target model answering each launched cycle after a chosen delay
module pct_pci_target (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// launch from the bridge
	input  wire logic        pciReq,
	// answer to the bridge
	output logic             pciDone,
	output logic [31:0]      pciRdata,
	// steering from the bench, launch count back to it
	input  wire logic [2:0]  delay,
	input  wire logic [31:0] readValue,
	output int               launches
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [2:0] waitCnt;
	logic       busy;

	// read data is only valid with the done pulse; elsewhere it toggles so stale use shows
	always @(posedge clk_sys)
	begin
		pciDone  <= 1'b0;
		pciRdata <= ~pciRdata;
		if (rst)
		begin
			busy     <= 1'b0;
			waitCnt  <= 3'h0;
			launches <= 0;
		end
		else if (pciReq)
		begin
			busy     <= 1'b1;
			waitCnt  <= delay;
			launches <= launches + 1;
		end
		else if (busy && waitCnt == 3'h0)
		begin
			busy     <= 1'b0;
			pciDone  <= 1'b1;
			pciRdata <= readValue;
		end
		else if (busy)
			waitCnt <= waitCnt - 3'h1;
	end
endmodule : pct_pci_target

/* sim/pct_translator_bench.sv */
// self-checking bench of the configuration cycle translator
module pct_translator_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        cpuReq = 1'b0;
	logic        cpuWrite = 1'b0;
	logic        bigEndianMode = 1'b1;
	logic [11:0] cpuAddr = 12'h000;
	logic [3:0]  cpuByteEn = 4'h0;
	logic [31:0] cpuWdata = 32'h00000000;
	logic [2:0]  delay = 3'h0;
	logic [31:0] readValue = 32'h00000000;
	logic        cpuAck, pciReq, pciDone;
	logic [3:0]  pciCmd, pciByteEn;
	logic [31:0] cpuRdata, pciAddr, pciWdata, pciRdata;
	logic [31:0] seed = 32'h361fc762;
	int          launches;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;

	pct_translator i_pct_translator (.clk_sys, .rst, .cpuReq, .cpuWrite, .cpuAddr, .cpuByteEn, .cpuWdata,
		.bigEndianMode, .cpuAck, .cpuRdata, .pciReq, .pciCmd, .pciAddr, .pciByteEn, .pciWdata, .pciDone, .pciRdata);
	pct_pci_target i_pct_pci_target (.clk_sys, .rst, .pciReq, .pciDone, .pciRdata, .delay, .readValue, .launches);

	initial forever #2 clk_sys = ~clk_sys;

	// a hang ends the run as a failure
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_of_test();
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [35:0] seen, input logic [35:0] want);
		checked++;
		if (seen !== want)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [31:0] swap(input logic [31:0] v);
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : swap

	// command and address phase value expected from a stored address register
	function automatic logic [35:0] cycle_of(input logic [31:0] a, input logic w, input logic [11:0] dOfs);
		logic [31:0] t;
		t = 32'h00000000;
		if (!a[31])
			return {w ? pct_pkg::CMD_IO_WR : pct_pkg::CMD_IO_RD, 20'h00000, dOfs};
		if (a[23:2] == {8'h00, 5'h1f, 3'h7, 6'h00})
			return {pct_pkg::CMD_SPECIAL, 32'h00000000};
		if (a[23:16] != 8'h00)
			t = {8'h00, a[23:2], 2'b01};
		else
		begin
			if (a[15:11] < 5'h15)
				t[pct_pkg::IDSEL_LSB + a[15:11]] = 1'b1;
			t[10:2] = a[10:2];
		end
		return {w ? pct_pkg::CMD_CFG_WR : pct_pkg::CMD_CFG_RD, t};
	endfunction : cycle_of

	// one processor access: request for one cycle, qualifiers held until the ack
	task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		#1;
		cpuReq    = 1'b1;
		cpuWrite  = w;
		cpuAddr   = a;
		cpuByteEn = be;
		cpuWdata  = d;
		@(posedge clk_sys);
		#1;
		cpuReq = 1'b0;
		while (cpuAck !== 1'b1 && n < 40)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check({35'h0, cpuAck}, 36'h1);
		q = cpuRdata;
	endtask : acc

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] r, a, st, d, q;
		logic [11:0] aOfs, dOfs;
		logic [3:0]  be;
		logic        w, bigE;
		int          n0;
		repeat (20) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		acc(1'b0, pct_pkg::OFS_LOW_WORD, 4'hf, 32'h0, q);
		check(36'(q), 36'(pct_pkg::ADDR_RESET));
		acc(1'b0, 12'h100, 4'hf, 32'h0, q);
		check(36'(q), 36'h0);
		for (int i = 0; i < 80; i++)
		begin
			r = rnd();
			a = rnd();
			bigE = r[0];
			bigEndianMode = bigE;
			case (r[3:1])
				3'h0: a[31:2] = {1'b1, a[30:24], 8'h00, 5'h1f, 3'h7, 6'h00};
				3'h1: a[31:2] = {1'b1, a[30:24], r[15:8] | 8'h01, 5'h1f, 3'h7, 6'h00};
				3'h2: a[31:16] = {1'b1, a[30:24], 8'h00};
				3'h3: a[31] = 1'b0;
				default: a[31] = 1'b1;
			endcase
			st   = a & pct_pkg::ADDR_WR_MASK;
			aOfs = bigE ? pct_pkg::OFS_LOW_WORD : pct_pkg::OFS_HIGH_WORD;
			dOfs = bigE ? pct_pkg::OFS_HIGH_WORD : pct_pkg::OFS_LOW_WORD;
			acc(1'b1, aOfs, 4'hf, bigE ? a : swap(a), q);
			check(36'(q), 36'h0);
			w  = r[4];
			be = (r[8:5] == 4'h0) ? 4'hf : r[8:5];
			d  = rnd();
			delay     = r[11:9];
			readValue = rnd();
			n0 = launches;
			acc(w, dOfs, be, d, q);
			check(36'(launches - n0), 36'h1);
			check({pciCmd, pciAddr}, cycle_of(st, w, dOfs));
			check(36'(pciByteEn), 36'(bigE ? be : {be[0], be[1], be[2], be[3]}));
			if (w)
				check(36'(pciWdata), 36'(bigE ? d : swap(d)));
			check(36'(q), 36'(w ? 32'h0 : (bigE ? readValue : swap(readValue))));
			// the pci cycle must leave the address register untouched
			acc(1'b0, aOfs, 4'hf, 32'h0, q);
			check(36'(bigE ? q : swap(q)), 36'(st));
			check(36'(launches - n0), 36'h1);
		end
		// mid-run reset: enable and launched fields clear, data port falls back to i/o
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		check({pciCmd, pciAddr}, 36'h0);
		acc(1'b0, aOfs, 4'hf, 32'h0, q);
		check(36'(q), 36'(pct_pkg::ADDR_RESET));
		acc(1'b1, dOfs, 4'hf, rnd(), q);
		check({pciCmd, pciAddr}, cycle_of(32'h00000000, 1'b1, dOfs));
		check(36'(launches), 36'h1);
		end_of_test();
	end
endmodule : pct_translator_bench
